// file: verilog/diff_adc_serial_readout.sv
/*
 Serial readout and conversion control of a 12-bit differential sampling converter.
 Assumes chip select and serial clock arrive from a host outside the clock domain,
 and that the converter core offers signed results with valid/ready.
*/
// How it works
// RULE1: Normal operation with chip select low, power-down output whenever it is high.
// RULE2: A falling chip select starts a new conversion frame.
// RULE3: Frame is sixteen bits: four nulls, then twelve result bits MSB first.
// RULE4: Output changes after serial clock falls; host samples on the next rise.
// RULE5: Serial clock edges pace the transfer and advance the conversion count.
// RULE6: Result bits are the signed differential value in two's complement.
// RULE7: Host keeps serial clock between 8 and 16 MHz.
// RULE8: Host keeps sample rate between 500 kSPS and 1 MSPS.
// RULE9: Host gives sixteen clocks per frame, then raises chip select.
// RULE10: Serial output is released while chip select is high.
`default_nettype none

module diff_adc_serial_readout
(
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	input  wire adc_readout_pkg::linkIn_t              linkIn,
	output var  adc_readout_pkg::linkOut_t             linkOut,
	input  wire logic signed [adc_readout_pkg::RESULT_BITS-1:0] sampleData,
	input  wire logic                                  sampleValid,
	output var  logic                                  sampleReady,
	output var  logic                                  powerDown,
	output var  logic                                  frameBusy
);
	import adc_readout_pkg::*;

	// ============================================================
	// Elaboration check
	if (SCLK_MIN_PHASE_CYC < 2 || NULL_BITS + RESULT_BITS != FRAME_BITS)
	begin : g_badTiming
		$error("system clock too slow for the serial clock or frame layout wrong");
	end

	// ============================================================
	// Pin synchronisers
	linkIn_t     sync1Q;
	linkIn_t     sync2Q;
	linkIn_t     sync3Q;
	linkIn_t     stableQ;
	linkIn_t     stableD;
	logic        csFall;
	logic        csRise;
	logic        sclkFall;
	logic        sclkRise;

	// Three stages; a change counts once stages two and three agree
	always_comb
	begin
		stableD.csN  = (sync2Q.csN == sync3Q.csN) ? sync3Q.csN : stableQ.csN;
		stableD.sclk = (sync2Q.sclk == sync3Q.sclk) ? sync3Q.sclk : stableQ.sclk;
		csFall   = stableQ.csN & ~stableD.csN;
		csRise   = ~stableQ.csN & stableD.csN;
		sclkFall = stableQ.sclk & ~stableD.sclk;
		sclkRise = ~stableQ.sclk & stableD.sclk;
	end

	// Synchroniser registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1Q  <= '{csN: CSN_RESET, sclk: SCLK_RESET};
			sync2Q  <= '{csN: CSN_RESET, sclk: SCLK_RESET};
			sync3Q  <= '{csN: CSN_RESET, sclk: SCLK_RESET};
			stableQ <= '{csN: CSN_RESET, sclk: SCLK_RESET};
		end
		else
		begin
			sync1Q  <= linkIn;
			sync2Q  <= sync1Q;
			sync3Q  <= sync2Q;
			stableQ <= stableD;
		end
	end

	// ============================================================
	// Result buffer
	logic [RESULT_BITS-1:0] bufData;
	logic                   bufValid;
	logic                   bufPop;

	adc_sample_fifo
	#(
		.WIDTH (RESULT_BITS),
		.DEPTH (BUF_DEPTH)
	)
	u_resultBuf
	(
		.clk      (clk),
		.rst      (rst),
		.inData   (sampleData),
		.inValid  (sampleValid),
		.inReady  (sampleReady),
		.outData  (bufData),
		.outValid (bufValid),
		.outReady (bufPop)
	);

	// ============================================================
	// Frame engine
	frameState_t stateQ;
	frameState_t stateD;
	logic [15:0] shiftQ;
	logic [15:0] shiftD;
	logic [4:0]  bitCntQ;
	logic [4:0]  bitCntD;
	linkOut_t    outQ;
	linkOut_t    outD;
	logic        pdQ;
	logic        pdD;

	assign linkOut   = outQ;
	assign powerDown = pdQ;

	// Next frame state from chip select and serial clock edges
	always_comb
	begin
		stateD = stateQ;
		shiftD = shiftQ;
		bitCntD = bitCntQ;
		outD   = outQ;
		bufPop = 1'b0;
		pdD    = stableD.csN; // RULE1
		if (csRise)
		begin
			stateD      = ST_IDLE;
			outD.sdo    = SDO_RESET;
			outD.sdoOeN = SDO_OEN_RESET; // RULE10
		end
		else
		begin
			unique case (stateQ)
				ST_IDLE:
				begin
					if (csFall) // RULE2
					begin
						stateD = ST_SHIFT;
						// Empty buffer sends a zero result rather than a stale one
						shiftD = {NULL_FIELD, bufValid ? bufData : 12'h000}; // RULE3 RULE6
						bufPop = bufValid;
						bitCntD = BITCNT_RESET;
						outD.sdo    = shiftD[FRAME_BITS-1];
						outD.sdoOeN = 1'b0;
					end
				end
				ST_SHIFT:
				begin
					if (sclkRise) // RULE5
					begin
						bitCntD = bitCntQ + 5'h01;
						if (bitCntQ == 5'(FRAME_BITS - 1))
						begin
							stateD = ST_DONE;
						end
					end
					if (sclkFall) // RULE4
					begin
						shiftD   = {shiftQ[14:0], 1'b0};
						outD.sdo = shiftQ[FRAME_BITS-2]; // RULE3
					end
				end
				ST_DONE:
				begin
					if (sclkFall)
					begin
						outD.sdo = 1'b0; // Trailing clocks shift out zeros
					end
				end
				default:
				begin
					stateD = ST_IDLE;
				end
			endcase
		end
	end

	// Frame registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stateQ    <= ST_IDLE;
			shiftQ    <= SHIFT_RESET;
			bitCntQ   <= BITCNT_RESET;
			outQ      <= '{sdo: SDO_RESET, sdoOeN: SDO_OEN_RESET};
			pdQ       <= PD_RESET;
			frameBusy <= 1'b0;
		end
		else
		begin
			stateQ    <= stateD;
			shiftQ    <= shiftD;
			bitCntQ   <= bitCntD;
			outQ      <= outD;
			pdQ       <= pdD;
			frameBusy <= (stateD == ST_SHIFT);
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_frameStart;
		csFall ##1 (stateQ == ST_SHIFT);
	endsequence

	property p_powerDown;
		!stableD.csN |=> !pdQ ##0 (stableD.csN || !pdQ);
	endproperty
	a_powerDown: assert property (p_powerDown) // RULE1
		else $error("power-down not cleared while selected");

	property p_pdHigh;
		csRise |=> pdQ ##1 (pdQ || !stableQ.csN);
	endproperty
	a_pdHigh: assert property (p_pdHigh) // RULE1
		else $error("power-down not entered after deselect");

	property p_start;
		(csFall && stateQ == ST_IDLE) |-> s_frameStart;
	endproperty
	a_start: assert property (p_start) // RULE2
		else $error("chip select fall did not start a frame");

	property p_nulls;
		(csFall && stateQ == ST_IDLE) |=> (shiftQ[15:12] == 4'h0) && !outQ.sdo && bitCntQ == 5'h00;
	endproperty
	a_nulls: assert property (p_nulls) // RULE3
		else $error("frame does not open with null bits");

	property p_result;
		(csFall && stateQ == ST_IDLE && bufValid) |=> shiftQ[11:0] == $past(bufData);
	endproperty
	a_result: assert property (p_result) // RULE6
		else $error("frame word differs from buffered result");

	property p_sdoTiming;
		(stableQ.csN == $past(stableQ.csN) && $changed(outQ.sdo)) |-> $past(sclkFall, 1);
	endproperty
	a_sdoTiming: assert property (p_sdoTiming) // RULE4
		else $error("serial output moved without a serial clock fall");

	property p_count;
		(stateQ == ST_SHIFT && bitCntQ == 5'(FRAME_BITS - 1) && sclkRise && !csRise)
			|=> (stateQ == ST_DONE) && bitCntQ == 5'h10;
	endproperty
	a_count: assert property (p_count) // RULE5
		else $error("frame did not end after sixteen clock rises");

	property p_release;
		stableQ.csN |-> outQ.sdoOeN; // Released in the same edge that registers chip select high
	endproperty
	a_release: assert property (p_release) // RULE10
		else $error("serial output still driven while deselected");

endmodule

`default_nettype wire

// file: shared/adc_readout_pkg.sv
/*
 Shared constants and types for the differential converter serial readout.
 Assumes one 100 MHz system clock and a serial host that drives chip select and serial clock.
*/
`default_nettype none

package adc_readout_pkg;

	// ============================================================
	// Clocking and link timing
	localparam int CLK_MHZ        = 100;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SCLK_MIN_MHZ   = 8;
	localparam int SCLK_MAX_MHZ   = 16;
	localparam int SPS_MIN_KSPS   = 500;
	localparam int SPS_MAX_KSPS   = 1000;
	// Shortest serial clock phase in system cycles, rounded down
	localparam int SCLK_MIN_PHASE_CYC = CLK_MHZ / (2 * SCLK_MAX_MHZ);
	localparam int SYNC_STAGES    = 3;

	// ============================================================
	// Frame layout
	localparam int FRAME_BITS     = 16;
	localparam int NULL_BITS      = 4;
	localparam int RESULT_BITS    = 12;
	localparam int BUF_DEPTH      = 2;

	// ============================================================
	// Values after reset
	localparam logic        SDO_RESET    = 1'h0;
	localparam logic        SDO_OEN_RESET = 1'h1;
	localparam logic        PD_RESET     = 1'h1;
	localparam logic        CSN_RESET    = 1'h1;
	localparam logic        SCLK_RESET   = 1'h0;
	localparam logic [15:0] SHIFT_RESET  = 16'h0000;
	localparam logic [4:0]  BITCNT_RESET = 5'h00;
	localparam logic [3:0]  NULL_FIELD   = 4'h0;

	// ============================================================
	// Types
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE  = 2'b10
	} frameState_t;

	typedef struct packed
	{
		logic csN;
		logic sclk;
	} linkIn_t;

	typedef struct packed
	{
		logic sdo;
		logic sdoOeN;
	} linkOut_t;

endpackage

`default_nettype wire

// file: verilog/adc_sample_fifo.sv
/*
 Small valid/ready buffer for conversion results on their way to the serial frame.
 Assumes both sides run on the same clock; the drain side may stall at will.
*/
`default_nettype none

module adc_sample_fifo
#(
	parameter int WIDTH = 12,
	parameter int DEPTH = 2
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output var  logic             inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	import adc_readout_pkg::*;

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ============================================================
	// Elaboration check
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
	begin : g_badParam
		$error("adc_sample_fifo needs a power-of-two depth of two or more");
	end

	// ============================================================
	// Storage and pointers
	logic [WIDTH-1:0] memQ     [DEPTH];
	logic [WIDTH-1:0] memD     [DEPTH];
	logic [PTR_W-1:0] wrPtrQ;
	logic [PTR_W-1:0] wrPtrD;
	logic [PTR_W-1:0] rdPtrQ;
	logic [PTR_W-1:0] rdPtrD;
	logic [PTR_W:0]   countQ;
	logic [PTR_W:0]   countD;
	logic             inReadyQ;
	logic             inReadyD;
	logic             push;
	logic             pop;

	assign inReady  = inReadyQ;
	assign outValid = (countQ != '0);
	assign outData  = memQ[rdPtrQ];

	// Next state: push when not full, pop when the frame takes a word
	always_comb
	begin
		push   = inValid & inReadyQ;
		pop    = outValid & outReady;
		memD   = memQ;
		wrPtrD = wrPtrQ;
		rdPtrD = rdPtrQ;
		countD = countQ;
		if (push)
		begin
			memD[wrPtrQ] = inData;
			wrPtrD       = wrPtrQ + 1'b1;
		end
		if (pop)
		begin
			rdPtrD = rdPtrQ + 1'b1;
		end
		case ({push, pop})
			2'b10:   countD = countQ + 1'b1;
			2'b01:   countD = countQ - 1'b1;
			default: countD = countQ;
		endcase
		inReadyD = (countD != (PTR_W+1)'(DEPTH)); // Honest full, registered
	end

	// Registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wrPtrQ   <= '0;
			rdPtrQ   <= '0;
			countQ   <= '0;
			inReadyQ <= 1'b0;
		end
		else
		begin
			wrPtrQ   <= wrPtrD;
			rdPtrQ   <= rdPtrD;
			countQ   <= countD;
			inReadyQ <= inReadyD;
		end
		memQ <= memD;
	end

endmodule

`default_nettype wire

// file: sim/serial_host_model.sv
/*
 Behavioural serial host: drives chip select and serial clock, captures the frame.
 Assumes the bench clk at 100 MHz; every pin change lands on its falling edge.
*/
`default_nettype none

module serial_host_model
(
	input  wire logic clk,
	input  wire logic sdoLine,
	output var  logic csN,
	output var  logic sclk
);
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Idle: deselected, clock parked low between frames
	initial
	begin
		csN = 1'b1;
		sclk = 1'b0;
	end

	// One bit of 4+4 clk phases (80 ns); bit read late in the high phase,
	// clear of the receiver's resync delay
	task automatic runFrame(input int rises, output logic [15:0] word);
		word = 16'h0000;
		@(negedge clk) csN <= 1'b0;
		repeat (8) @(negedge clk);
		for (int i = 0; i < rises; i++)
		begin
			@(negedge clk) sclk <= 1'b1;
			repeat (3) @(negedge clk);
			word = {word[14:0], sdoLine};
			@(negedge clk) sclk <= 1'b0;
			repeat (3) @(negedge clk);
		end
		@(negedge clk) csN <= 1'b1;
		repeat (10) @(negedge clk);
	endtask
endmodule

`default_nettype wire

// file: sim/diff_adc_serial_readout_tb.sv
/*
 Self-checking bench for the converter serial readout.
 Assumes the host model file and the shared package are compiled first.
*/
`default_nettype none

module diff_adc_serial_readout_tb;
	import adc_readout_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed
	{
		logic [11:0] word;
		logic [15:0] frame;
	} row_t;

	logic                     clk;
	logic                     rst;
	logic                     csN;
	logic                     sclk;
	logic                     sampleValid;
	logic signed [11:0]       sampleData;
	logic                     sampleReady;
	logic                     powerDown;
	logic                     frameBusy;
	linkIn_t                  linkIn;
	linkOut_t                 linkOut;
	tri1                      sdoLine;
	int                       miscompares = 0;
	int                       compares = 0;
	int                       csHigh = 0;
	int                       csLow = 0;
	logic [15:0]              got;
	row_t                     rows [5] = '{'{12'h7FF, 16'h07FF}, '{12'h800, 16'h0800},
		'{12'hFFF, 16'h0FFF}, '{12'h001, 16'h0001}, '{12'hA5C, 16'h0A5C}};

	// ============================================================
	// Wiring; released data line is pulled high
	assign linkIn = {csN, sclk};
	assign sdoLine = linkOut.sdoOeN ? 1'bz : linkOut.sdo;

	diff_adc_serial_readout DUT
	(
		.clk         (clk),
		.rst         (rst),
		.linkIn      (linkIn),
		.linkOut     (linkOut),
		.sampleData  (sampleData),
		.sampleValid (sampleValid),
		.sampleReady (sampleReady),
		.powerDown   (powerDown),
		.frameBusy   (frameBusy)
	);

	serial_host_model host
	(
		.clk     (clk),
		.sdoLine (sdoLine),
		.csN     (csN),
		.sclk    (sclk)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ============================================================
	// Checking and closing
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Offer one word; held until the edge where ready is seen high
	task automatic pushWord(input logic [11:0] w);
		int i;
		@(negedge clk);
		sampleData <= w;
		sampleValid <= 1'b1;
		for (i = 0; i < 400 && sampleReady !== 1'b1; i++)
			@(negedge clk);
		if (i == 400)
		begin
			check("ready wait", 16'h0001, 16'h0000);
			summarize();
		end
		@(posedge clk);
		@(negedge clk);
		sampleValid <= 1'b0;
	endtask

	// Settled chip select level shows on power-down and data enable
	always @(negedge clk)
	begin
		csHigh <= csN ? csHigh + 1 : 0;
		csLow <= csN ? 0 : csLow + 1;
		if (rst === 1'b0 && csHigh > 6)
		begin
			check("powerDown idle", 16'h0001, powerDown);
			check("sdoOeN idle", 16'h0001, linkOut.sdoOeN);
			check("sdo line idle", 16'h0001, sdoLine);
		end
		if (rst === 1'b0 && csLow > 6)
			check("powerDown active", 16'h0000, powerDown);
		// Every frame is still shifting twenty cycles after chip select falls
		if (rst === 1'b0 && csLow == 20)
			check("busy in frame", 16'h0001, frameBusy);
	end

	// ============================================================
	// Main sequence
	initial
	begin
		rst = 1'b1;
		sampleValid = 1'b0;
		sampleData = 12'h000;
		repeat (6) @(negedge clk);
		check("reset sdoOeN", 16'h0001, linkOut.sdoOeN);
		check("reset busy", 16'h0000, frameBusy);
		check("reset ready", 16'h0000, sampleReady);
		rst <= 1'b0;
		repeat (6) @(negedge clk);
		check("ready after reset", 16'h0001, sampleReady);
		foreach (rows[i])
		begin
			pushWord(rows[i].word);
			host.runFrame(16, got);
			check("frame", rows[i].frame, got);
			check("busy after frame", 16'h0000, frameBusy);
		end
		// Fill the buffer until refused, then drain it with frames spaced out by idle gaps
		pushWord(12'h123);
		pushWord(12'h9AB);
		@(negedge clk);
		sampleData <= 12'h456;
		sampleValid <= 1'b1;
		repeat (3) @(negedge clk);
		check("ready when full", 16'h0000, sampleReady);
		sampleValid <= 1'b0;
		repeat (20) @(negedge clk);
		host.runFrame(16, got);
		check("oldest first", {NULL_FIELD, 12'h123}, got);
		repeat (30) @(negedge clk);
		host.runFrame(16, got);
		check("second word", {NULL_FIELD, 12'h9AB}, got);
		host.runFrame(16, got);
		check("empty buffer", 16'h0000, got);
		// Chip select raised in mid-frame, then a fresh conversion
		pushWord(12'hF0F);
		host.runFrame(8, got);
		check("aborted bits", 16'h000F, got);
		check("aborted busy", 16'h0000, frameBusy);
		pushWord(12'h3C3);
		host.runFrame(16, got);
		check("after abort", 16'h03C3, got);
		// Reset in mid-run drops the buffered word and leaves the line released
		pushWord(12'h555);
		@(negedge clk);
		rst <= 1'b1;
		repeat (2) @(negedge clk);
		check("mid reset ready", 16'h0000, sampleReady);
		check("mid reset sdoOeN", 16'h0001, linkOut.sdoOeN);
		rst <= 1'b0;
		repeat (6) @(negedge clk);
		check("ready after mid reset", 16'h0001, sampleReady);
		host.runFrame(16, got);
		check("frame after reset", 16'h0000, got);
		summarize();
	end
endmodule

`default_nettype wire
